// >>> logic/pcr_pkg.sv
// command codes, reset values and carriers for the command register bank
// assumes a link-side engine that delivers decoded command transfers
package pcr_pkg;
    localparam logic [15:0] CMD_PAGE = 16'h0000;
    localparam logic [15:0] CMD_SWITCH = 16'h0001;
    localparam logic [15:0] CMD_CLEAR = 16'h0003;
    localparam logic [15:0] CMD_WRITE_LOCK = 16'h0010;
    localparam logic [15:0] CMD_FEATURE = 16'h0019;
    localparam logic [15:0] CMD_COMM_STATUS = 16'h007E;
    localparam logic [15:0] CMD_COMM_SET = 16'hFEC6;
    localparam logic [15:0] CMD_SYS1_SET = 16'hFECA;
    localparam logic [15:0] CMD_TEMP_MASK = 16'hFED5;
    localparam logic [15:0] CMD_COMM_MASK = 16'hFED6;
    localparam logic [15:0] CMD_VENDOR_MASK = 16'hFED8;
    localparam logic [15:0] CMD_SYS1_MASK = 16'hFEDA;
    localparam logic [15:0] CMD_SYS2_MASK = 16'hFEDC;
    localparam logic [15:0] CMD_SYS1_STATUS = 16'hFEE0;
    localparam logic [15:0] CMD_AVG_SEL = 16'hFEE2;
    // readings: vin, vout, iout, temp, pin
    localparam logic [15:0] READ_STD [5] = '{16'h0088, 16'h008B, 16'h008C, 16'h008D, 16'h0097};
    localparam logic [15:0] READ_RAW [5] = '{16'hFE10, 16'hFE18, 16'hFE00, 16'hFE48, 16'hFE08};
    // limits: standard code, alias code, reset value
    localparam logic [15:0] LIMIT_STD [8] = '{16'h0042, 16'h0043, 16'h004A, 16'h0051,
                                              16'h0052, 16'h0057, 16'h0058, 16'h006B};
    localparam logic [15:0] LIMIT_ALIAS [8] = '{16'hFE1D, 16'hFE1C, 16'hFE05, 16'hFE4D,
                                                16'hFE4C, 16'hFE15, 16'hFE14, 16'hFE0D};
    localparam logic [15:0] LIMIT_RESET [8] = '{16'h7FFF, 16'h0000, 16'h7FFF, 16'h7FFF,
                                                16'h0000, 16'h7FFF, 16'h0000, 16'h7FFF};
    localparam int SWITCH_ON_BIT = 7;
    localparam int LOCK_FULL_BIT = 7;
    localparam int LOCK_PARTIAL_BIT = 6;
    localparam int AVG_SHOW_BIT = 0;
    localparam logic [7:0] FEATURE_VALUE = 8'hD0;
    localparam logic [7:0] TEMP_MASK_RESET = 8'hE0;
    localparam logic [7:0] COMM_MASK_RESET = 8'hE3;
    localparam logic [7:0] VENDOR_MASK_RESET = 8'hFF;
    localparam logic [15:0] SYS1_MASK_RESET = 16'h3CFE;
    localparam logic [15:0] SYS2_MASK_RESET = 16'hCFFF;
    // latched status cleared by a rising switch command bit
    localparam logic [7:0] ON_RISE_COMM_CLR = 8'hFF;
    localparam logic [15:0] ON_RISE_SYS1_CLR = 16'h00FF;
    // edges after reset release before the synchronised strap is loaded
    localparam logic [1:0] BOOT_LOAD = 2'h2;
    localparam logic [1:0] BOOT_DONE = 2'h3;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_LOCKED = 2'h1;
    localparam logic [1:0] RESP_BAD = 2'h2;

    typedef struct packed {
        logic [15:0] vin;
        logic [15:0] vout;
        logic [15:0] iout;
        logic [15:0] temp;
        logic [15:0] pin;
    } pcr_adc_t;

    typedef struct packed {
        logic write;
        logic [15:0] code;
        logic [15:0] wdata;
    } pcr_req_t;

    typedef struct packed {
        logic [1:0] status;
        logic [15:0] rdata;
    } pcr_rsp_t;
endpackage

// >>> logic/pcr_bank.sv
// command register bank: link-side request capture and core register file
// assumes a protocol engine on link_clk that holds a request until the bank takes it
`timescale 1ns/1ps
module pcr_bank (
    // core clock and reset
    input wire logic clk,
    input wire logic rst,
    // link clock and reset
    input wire logic link_clk,
    input wire logic link_rst,
    // command transfers on link_clk
    input wire logic cmd_valid,
    input wire pcr_pkg::pcr_req_t cmd_req,
    output logic cmd_busy,
    output logic cmd_done,
    output pcr_pkg::pcr_rsp_t cmd_rsp,
    // converter results and status events on clk
    input wire pcr_pkg::pcr_adc_t adc_avg,
    input wire pcr_pkg::pcr_adc_t adc_raw,
    input wire logic [7:0] comm_event,
    input wire logic [15:0] sys1_event,
    input wire logic reboot,
    // pins
    input wire logic strap_six_input,
    input wire logic enable_in,
    output logic switch_on,
    output logic alert
);
    typedef struct packed {
        logic [2:0] req_sync;
        logic [1:0] en_sync;
        logic [1:0] strap_sync;
        logic [1:0] boot_cnt;
        logic on_bit;
        logic lock_full;
        logic lock_partial;
        logic show_avg;
        logic [7:0] page;
        logic [7:0] temp_mask;
        logic [7:0] comm_mask;
        logic [7:0] vendor_mask;
        logic [15:0] sys1_mask;
        logic [15:0] sys2_mask;
        logic [7:0][15:0] limits;
        logic [7:0] comm_stat;
        logic [15:0] sys1_stat;
        pcr_pkg::pcr_rsp_t rsp;
        logic ack_tgl;
        logic switch_on;
        logic alert;
    } pcr_core_t;

    typedef struct packed {
        logic req_tgl;
        logic [2:0] ack_sync;
        logic busy;
        logic done;
        pcr_pkg::pcr_req_t req;
        pcr_pkg::pcr_rsp_t rsp;
    } pcr_link_t;

    pcr_core_t core_reg;
    pcr_core_t core_next;
    pcr_link_t link_reg;
    pcr_link_t link_next;

    // hit flag and slot of a limit, found by either of its two codes
    function automatic logic [3:0] limit_slot(input logic [15:0] code);
        logic [3:0] s;
        s = 4'h0;
        for (int i = 0; i < 8; i++) begin
            if (code == pcr_pkg::LIMIT_STD[i] || code == pcr_pkg::LIMIT_ALIAS[i]) begin
                s = {1'b1, 3'(i)};
            end
        end
        return s;
    endfunction

    function automatic logic write_allowed(input logic [15:0] code, input logic full,
                                           input logic partial);
        logic ok;
        ok = 1'b1;
        if (full) begin
            ok = (code == pcr_pkg::CMD_WRITE_LOCK) || (code == pcr_pkg::CMD_PAGE);
        end else if (partial) begin
            ok = (code == pcr_pkg::CMD_WRITE_LOCK) || (code == pcr_pkg::CMD_PAGE)
                || (code == pcr_pkg::CMD_SWITCH) || (code == pcr_pkg::CMD_CLEAR);
        end
        return ok;
    endfunction

    function automatic logic [15:0] pick(input logic [15:0] avg, input logic [15:0] raw,
                                         input logic show);
        return show ? avg : raw;
    endfunction

    always_comb begin
        logic new_req;
        logic [3:0] slot;
        logic [1:0] st;
        logic [15:0] rd;
        pcr_pkg::pcr_req_t r;
        new_req = 1'b0;
        slot = 4'h0;
        st = pcr_pkg::RESP_OK;
        rd = 16'h0000;
        r = link_reg.req;
        core_next = core_reg;
        // strap and enable are pins; only the second flop is read
        core_next.req_sync = {core_reg.req_sync[1:0], link_reg.req_tgl};
        core_next.en_sync = {core_reg.en_sync[0], enable_in};
        core_next.strap_sync = {core_reg.strap_sync[0], strap_six_input};
        new_req = core_reg.req_sync[2] ^ core_reg.req_sync[1];
        slot = limit_slot(r.code);
        if (new_req) begin
            if (r.write) begin
                if (!write_allowed(r.code, core_reg.lock_full, core_reg.lock_partial)) begin
                    st = pcr_pkg::RESP_LOCKED;
                end else begin
                    case (r.code)
                        pcr_pkg::CMD_PAGE: core_next.page = r.wdata[7:0];
                        pcr_pkg::CMD_SWITCH: begin
                            core_next.on_bit = r.wdata[pcr_pkg::SWITCH_ON_BIT];
                        end
                        pcr_pkg::CMD_CLEAR: begin
                            core_next.comm_stat = 8'h00;
                            core_next.sys1_stat = 16'h0000;
                        end
                        pcr_pkg::CMD_WRITE_LOCK: begin
                            core_next.lock_full = r.wdata[pcr_pkg::LOCK_FULL_BIT];
                            core_next.lock_partial = r.wdata[pcr_pkg::LOCK_PARTIAL_BIT];
                        end
                        pcr_pkg::CMD_AVG_SEL: core_next.show_avg = r.wdata[pcr_pkg::AVG_SHOW_BIT];
                        pcr_pkg::CMD_TEMP_MASK: core_next.temp_mask = r.wdata[7:0];
                        pcr_pkg::CMD_COMM_MASK: core_next.comm_mask = r.wdata[7:0];
                        pcr_pkg::CMD_VENDOR_MASK: core_next.vendor_mask = r.wdata[7:0];
                        pcr_pkg::CMD_SYS1_MASK: core_next.sys1_mask = r.wdata;
                        pcr_pkg::CMD_SYS2_MASK: core_next.sys2_mask = r.wdata;
                        pcr_pkg::CMD_COMM_SET: begin
                            core_next.comm_stat = core_reg.comm_stat | r.wdata[7:0];
                        end
                        pcr_pkg::CMD_SYS1_SET: begin
                            core_next.sys1_stat = core_reg.sys1_stat | r.wdata;
                        end
                        pcr_pkg::CMD_COMM_STATUS: begin
                            core_next.comm_stat = core_reg.comm_stat & ~r.wdata[7:0];
                        end
                        pcr_pkg::CMD_SYS1_STATUS: begin
                            core_next.sys1_stat = core_reg.sys1_stat & ~r.wdata;
                        end
                        default: begin
                            if (slot[3]) begin
                                core_next.limits[slot[2:0]] = r.wdata;
                            end else begin
                                st = pcr_pkg::RESP_BAD;
                            end
                        end
                    endcase
                end
            end else begin
                case (r.code)
                    pcr_pkg::CMD_PAGE: rd = {8'h00, core_reg.page};
                    pcr_pkg::CMD_SWITCH: rd = {8'h00, core_reg.on_bit, 7'h00};
                    pcr_pkg::CMD_WRITE_LOCK: begin
                        rd = {8'h00, core_reg.lock_full, core_reg.lock_partial, 6'h00};
                    end
                    pcr_pkg::CMD_FEATURE: rd = {8'h00, pcr_pkg::FEATURE_VALUE};
                    pcr_pkg::CMD_AVG_SEL: rd = {15'h0000, core_reg.show_avg};
                    pcr_pkg::CMD_TEMP_MASK: rd = {8'h00, core_reg.temp_mask};
                    pcr_pkg::CMD_COMM_MASK: rd = {8'h00, core_reg.comm_mask};
                    pcr_pkg::CMD_VENDOR_MASK: rd = {8'h00, core_reg.vendor_mask};
                    pcr_pkg::CMD_SYS1_MASK: rd = core_reg.sys1_mask;
                    pcr_pkg::CMD_SYS2_MASK: rd = core_reg.sys2_mask;
                    pcr_pkg::CMD_COMM_SET, pcr_pkg::CMD_COMM_STATUS: begin
                        rd = {8'h00, core_reg.comm_stat};
                    end
                    pcr_pkg::CMD_SYS1_SET, pcr_pkg::CMD_SYS1_STATUS: rd = core_reg.sys1_stat;
                    pcr_pkg::READ_STD[0]: rd = pick(adc_avg.vin, adc_raw.vin, core_reg.show_avg);
                    pcr_pkg::READ_STD[1]: rd = pick(adc_avg.vout, adc_raw.vout, core_reg.show_avg);
                    pcr_pkg::READ_STD[2]: rd = pick(adc_avg.iout, adc_raw.iout, core_reg.show_avg);
                    pcr_pkg::READ_STD[3]: rd = pick(adc_avg.temp, adc_raw.temp, core_reg.show_avg);
                    pcr_pkg::READ_STD[4]: rd = pick(adc_avg.pin, adc_raw.pin, core_reg.show_avg);
                    pcr_pkg::READ_RAW[0]: rd = adc_raw.vin;
                    pcr_pkg::READ_RAW[1]: rd = adc_raw.vout;
                    pcr_pkg::READ_RAW[2]: rd = adc_raw.iout;
                    pcr_pkg::READ_RAW[3]: rd = adc_raw.temp;
                    pcr_pkg::READ_RAW[4]: rd = adc_raw.pin;
                    default: begin
                        if (slot[3]) begin
                            rd = core_reg.limits[slot[2:0]];
                        end else begin
                            st = pcr_pkg::RESP_BAD;
                        end
                    end
                endcase
            end
            core_next.rsp = {st, rd};
            core_next.ack_tgl = ~core_reg.ack_tgl;
        end
        // strap is loaded once its synchroniser has filled
        if (reboot) begin
            core_next.boot_cnt = 2'h0;
        end else if (core_reg.boot_cnt != pcr_pkg::BOOT_DONE) begin
            core_next.boot_cnt = core_reg.boot_cnt + 2'h1;
        end
        if (!reboot && core_reg.boot_cnt == pcr_pkg::BOOT_LOAD) begin
            core_next.on_bit = core_reg.strap_sync[1];
        end
        if (core_next.on_bit && !core_reg.on_bit) begin
            core_next.comm_stat = core_next.comm_stat & ~pcr_pkg::ON_RISE_COMM_CLR;
            core_next.sys1_stat = core_next.sys1_stat & ~pcr_pkg::ON_RISE_SYS1_CLR;
        end
        // events last so that a set in the clearing cycle survives
        core_next.comm_stat = core_next.comm_stat | comm_event;
        core_next.sys1_stat = core_next.sys1_stat | sys1_event;
        core_next.switch_on = core_next.on_bit & core_reg.en_sync[1];
        core_next.alert = (|(core_next.comm_stat & ~core_next.comm_mask))
            | (|(core_next.sys1_stat & ~core_next.sys1_mask));
        if (rst) begin
            core_next = '0;
            core_next.temp_mask = pcr_pkg::TEMP_MASK_RESET;
            core_next.comm_mask = pcr_pkg::COMM_MASK_RESET;
            core_next.vendor_mask = pcr_pkg::VENDOR_MASK_RESET;
            core_next.sys1_mask = pcr_pkg::SYS1_MASK_RESET;
            core_next.sys2_mask = pcr_pkg::SYS2_MASK_RESET;
            for (int i = 0; i < 8; i++) begin
                core_next.limits[i] = pcr_pkg::LIMIT_RESET[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        core_reg <= core_next;
    end

    // link side: request held stable while busy, so the core may read it directly
    always_comb begin
        link_next = link_reg;
        link_next.done = 1'b0;
        link_next.ack_sync = {link_reg.ack_sync[1:0], core_reg.ack_tgl};
        if (!link_reg.busy && cmd_valid) begin
            link_next.req = cmd_req;
            link_next.req_tgl = ~link_reg.req_tgl;
            link_next.busy = 1'b1;
        end
        if (link_reg.ack_sync[2] ^ link_reg.ack_sync[1]) begin
            link_next.busy = 1'b0;
            link_next.done = 1'b1;
            link_next.rsp = core_reg.rsp;
        end
        if (link_rst) begin
            link_next = '0;
        end
    end

    always_ff @(posedge link_clk) begin
        link_reg <= link_next;
    end

    assign cmd_busy = link_reg.busy;
    assign cmd_done = link_reg.done;
    assign cmd_rsp = link_reg.rsp;
    assign switch_on = core_reg.switch_on;
    assign alert = core_reg.alert;
endmodule // pcr_bank

// >>> tb/pcr_host.sv
// host-side model that offers one command transfer at a time
// assumes the bank answers every taken request with a one-cycle cmd_done
`timescale 1ns/1ps
module pcr_host (
    // answer side
    input wire logic link_clk,
    input wire logic cmd_busy,
    input wire logic cmd_done,
    // request side
    output logic cmd_valid,
    output pcr_pkg::pcr_req_t cmd_req
);
    initial begin
        cmd_valid = 1'b0;
        cmd_req = '0;
    end
    task automatic xfer(input logic w, input logic [15:0] c, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge link_clk);
        cmd_req = '{w, c, d};
        cmd_valid = 1'b1;
        // busy only moves on the rising edge, so its settled level here decides the take
        while (cmd_busy !== 1'b0 && n < 20) begin
            @(negedge link_clk);
            n++;
        end
        @(posedge link_clk);
        @(negedge link_clk);
        cmd_valid = 1'b0;
        // released lines carry junk so nothing leans on stale request bits
        cmd_req = ~cmd_req;
        while (cmd_done !== 1'b1 && n < 40) begin
            @(posedge link_clk);
            #1;
            n++;
        end
    endtask
endmodule // pcr_host

// >>> tb/pcr_bank_chk.sv
// concurrent checks on the command port and switch pin of the bank
// assumes each reset is held for at least two edges of its own clock
`timescale 1ns/1ps
module pcr_bank_chk (
    // clocks and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic link_rst,
    // command port
    input wire logic cmd_valid,
    input wire pcr_pkg::pcr_req_t cmd_req,
    input wire logic cmd_busy,
    input wire logic cmd_done,
    input wire pcr_pkg::pcr_rsp_t cmd_rsp,
    // pins
    input wire logic enable_in,
    input wire logic switch_on
);
    // command of the transfer in flight, so feature answers are judged by their code
    logic [15:0] code_reg;
    logic wr_reg;
    always_ff @(posedge link_clk) begin
        if (cmd_valid && !cmd_busy) begin
            code_reg <= cmd_req.code;
            wr_reg <= cmd_req.write;
        end
    end
    property p_take; @(posedge link_clk) disable iff (link_rst)
        cmd_valid && !cmd_busy |=> cmd_busy; endproperty
    a_take: assert property (p_take) else $error("request not taken");
    property p_answer; @(posedge link_clk) disable iff (link_rst)
        $rose(cmd_busy) |-> ##[1:3] cmd_done; endproperty
    a_answer: assert property (p_answer) else $error("answer late");
    property p_pulse; @(posedge link_clk) disable iff (link_rst)
        cmd_done |-> !cmd_busy ##1 !cmd_done; endproperty
    a_pulse: assert property (p_pulse) else $error("done longer than a cycle");
    property p_hold; @(posedge link_clk) disable iff (link_rst)
        !cmd_done |-> $stable(cmd_rsp); endproperty
    a_hold: assert property (p_hold) else $error("answer moved between dones");
    property p_feat; @(posedge link_clk) disable iff (link_rst) cmd_done && !wr_reg
        && code_reg == pcr_pkg::CMD_FEATURE |-> cmd_rsp == 18'h0_00d0; endproperty
    a_feat: assert property (p_feat) else $error("feature byte wrong");
    property p_ro; @(posedge link_clk) disable iff (link_rst) cmd_done && wr_reg
        && code_reg == pcr_pkg::CMD_FEATURE |-> cmd_rsp.status == 2'h2; endproperty
    a_ro: assert property (p_ro) else $error("feature byte accepted a write");
    property p_enoff; @(posedge clk) disable iff (rst)
        !enable_in [*4] |=> !switch_on; endproperty
    a_enoff: assert property (p_enoff) else $error("switch on with enable low");
    property p_rise; @(posedge clk) disable iff (rst)
        $rose(switch_on) |-> $past(enable_in, 3); endproperty
    a_rise: assert property (p_rise) else $error("switch rose without enable");
endmodule // pcr_bank_chk
bind pcr_bank pcr_bank_chk u_chk (.clk(clk), .rst(rst), .link_clk(link_clk), .link_rst(link_rst),
    .cmd_valid(cmd_valid), .cmd_req(cmd_req), .cmd_busy(cmd_busy), .cmd_done(cmd_done),
    .cmd_rsp(cmd_rsp), .enable_in(enable_in), .switch_on(switch_on));

// >>> tb/pcr_bank_tb.sv
// self-checking bench for the command register bank
// assumes the host model drives the command port; answers are checked off a queue
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
    $display("CHECK FAILED at %0t: got %h want %h", $time, a, b); end end
module pcr_bank_tb;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic link_rst = 1'b1;
    logic reboot = 1'b0;
    logic strap_six_input = 1'b1;
    logic enable_in = 1'b0;
    logic [7:0] comm_event = 8'h00;
    logic [15:0] sys1_event = 16'h0000;
    logic cmd_valid, cmd_busy, cmd_done, switch_on, alert;
    logic [15:0] v;
    logic [31:0] seed = 32'hf84d_bc81;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    pcr_pkg::pcr_req_t cmd_req;
    pcr_pkg::pcr_rsp_t cmd_rsp, exp_r;
    pcr_pkg::pcr_rsp_t exp_q[$];
    pcr_pkg::pcr_adc_t adc_avg, adc_raw;
    always #2.5 clk = ~clk;
    initial begin
        #13.1;
        forever #80 link_clk = ~link_clk;
    end
    pcr_host host (.link_clk(link_clk), .cmd_busy(cmd_busy), .cmd_done(cmd_done),
        .cmd_valid(cmd_valid), .cmd_req(cmd_req));
    pcr_bank dut (.clk(clk), .rst(rst), .link_clk(link_clk), .link_rst(link_rst),
        .cmd_valid(cmd_valid), .cmd_req(cmd_req), .cmd_busy(cmd_busy), .cmd_done(cmd_done),
        .cmd_rsp(cmd_rsp), .adc_avg(adc_avg), .adc_raw(adc_raw), .comm_event(comm_event),
        .sys1_event(sys1_event), .reboot(reboot), .strap_six_input(strap_six_input),
        .enable_in(enable_in), .switch_on(switch_on), .alert(alert));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] fld(input pcr_pkg::pcr_adc_t a, input int i);
        return a[79 - 16 * i -: 16];
    endfunction
    task automatic x(input logic w, input logic [15:0] c, input logic [15:0] d,
        input logic [1:0] st, input logic [15:0] r);
        exp_q.push_back(pcr_pkg::pcr_rsp_t'{st, r});
        host.xfer(w, c, d);
    endtask
    task automatic rd(input logic [15:0] c, input logic [15:0] r);
        x(1'b0, c, 16'h0000, pcr_pkg::RESP_OK, r);
    endtask
    task automatic wr(input logic [15:0] c, input logic [15:0] d);
        x(1'b1, c, d, pcr_pkg::RESP_OK, 16'h0000);
    endtask
    // pulse core-side inputs for one clk, then judge the pins once settled
    task automatic ev(input logic [24:0] p, input logic a, input logic s);
        @(negedge clk);
        {reboot, comm_event, sys1_event} = p;
        @(negedge clk);
        {reboot, comm_event, sys1_event} = '0;
        repeat (6) @(negedge clk);
        `CHK(alert, a)
        `CHK(switch_on, s)
    endtask
    always @(posedge link_clk) begin
        #1;
        if (cmd_done === 1'b1) begin
            exp_r = exp_q.pop_front();
            `CHK(cmd_rsp, exp_r)
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            $display("CHECK FAILED at %0t: run too long", $time);
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        adc_avg = 80'({xs(), xs(), xs()});
        adc_raw = 80'({xs(), xs(), xs()});
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge link_clk);
        link_rst = 1'b0;
        rd(16'hfed5, 16'h00e0);
        rd(16'hfed6, 16'h00e3);
        rd(16'hfed8, 16'h00ff);
        rd(16'hfeda, 16'h3cfe);
        rd(16'hfedc, 16'hcfff);
        rd(16'h0019, {8'h00, 1'b1, 2'b10, 1'b1, 4'h0});
        x(1'b1, 16'h0019, 16'h00ff, pcr_pkg::RESP_BAD, 16'h0000);
        x(1'b0, 16'hfe30, 16'h0000, pcr_pkg::RESP_BAD, 16'h0000);
        rd(16'h0001, 16'h0080);
        ev(25'h0, 1'b0, 1'b0);
        enable_in = 1'b1;
        ev(25'h0, 1'b0, 1'b1);
        wr(16'h0001, 16'h0000);
        ev(25'h0, 1'b0, 1'b0);
        ev(25'h100_0000, 1'b0, 1'b1);
        strap_six_input = 1'b0;
        ev(25'h100_0000, 1'b0, 1'b0);
        $display("test switch done");
        ev(25'h4_0000, 1'b1, 1'b0);
        rd(16'h007e, 16'h0004);
        wr(16'h007e, 16'h0004);
        ev(25'h1_0000, 1'b0, 1'b0);
        wr(16'hfec6, 16'h0010);
        rd(16'h007e, 16'h0011);
        wr(16'h007e, 16'h0010);
        ev(25'h1, 1'b1, 1'b0);
        rd(16'hfee0, 16'h0001);
        wr(16'hfeca, 16'h0002);
        rd(16'hfee0, 16'h0003);
        wr(16'h0001, 16'h0080);
        ev(25'h0, 1'b0, 1'b1);
        rd(16'h007e, 16'h0000);
        rd(16'hfee0, 16'h0000);
        $display("test status done");
        wr(16'h0010, 16'h0080);
        x(1'b1, 16'hfed6, 16'h0055, pcr_pkg::RESP_LOCKED, 16'h0000);
        x(1'b1, 16'h0001, 16'h0000, pcr_pkg::RESP_LOCKED, 16'h0000);
        wr(16'h0000, 16'h0001);
        ev(25'h0, 1'b0, 1'b1);
        wr(16'h0010, 16'h0040);
        rd(16'h0010, 16'h0040);
        wr(16'h0001, 16'h0000);
        wr(16'h0003, 16'h0000);
        x(1'b1, 16'hfeda, 16'h0055, pcr_pkg::RESP_LOCKED, 16'h0000);
        wr(16'h0010, 16'h0000);
        rd(16'hfed6, 16'h00e3);
        rd(16'hfeda, 16'h3cfe);
        $display("test lock done");
        v = 16'(xs());
        wr(16'hfed6, v);
        rd(16'hfed6, {8'h00, v[7:0]});
        wr(16'hfeda, v);
        rd(16'hfeda, v);
        for (int i = 0; i < 8; i++) begin
            rd(pcr_pkg::LIMIT_ALIAS[i], pcr_pkg::LIMIT_RESET[i]);
            v = 16'(xs());
            wr(pcr_pkg::LIMIT_STD[i], v);
            rd(pcr_pkg::LIMIT_ALIAS[i], v);
            wr(pcr_pkg::LIMIT_ALIAS[i], ~v);
            rd(pcr_pkg::LIMIT_STD[i], ~v);
        end
        for (int s = 0; s < 2; s++) begin
            wr(16'hfee2, 16'(s));
            for (int i = 0; i < 5; i++) begin
                rd(pcr_pkg::READ_STD[i], fld(s ? adc_avg : adc_raw, i));
                rd(pcr_pkg::READ_RAW[i], fld(adc_raw, i));
            end
        end
        $display("test data done");
        repeat (2) @(negedge link_clk);
        `CHK(exp_q.size(), 0)
        conclude();
    end
endmodule // pcr_bank_tb
